/* File: hw/pma_core.sv */
// Program-memory addressing for a small 8-bit core: counter, vectors, fetch.
// Assumes the core drives branch, interrupt and table requests synchronously.
`timescale 1ns/100ps
`default_nettype none
module pma_core
  import pma_pkg::*;
#(
  parameter int WORDS = PMA_WORDS_FULL
)
(
  // Clock and reset.
  input wire logic ref_clk,
  input wire logic rst,
  // Flow control from the execution unit.
  input wire logic irq_take,
  input wire logic branch,
  input wire logic [12:0] branch_addr,
  // Fetch output.
  output logic [12:0] pc,
  output logic [13:0] instr,
  // Table read of program memory by user code.
  input wire logic tbl_req,
  input wire logic [12:0] tbl_addr,
  output logic [13:0] tbl_word,
  output logic tbl_valid,
  // Independent data-memory bus.
  input wire logic dm_we,
  input wire logic [8:0] dm_addr,
  input wire logic [7:0] dm_wdata,
  output logic [7:0] dm_rdata,
  // Programming port of the store.
  input wire logic pgm_we,
  input wire logic [12:0] pgm_addr,
  input wire logic [13:0] pgm_word
);
  import pma_pkg::*;

  typedef struct packed {
    logic [12:0] pc;
    logic [13:0] instr;
    logic [13:0] tbl_word;
    logic tbl_valid;
    logic [7:0] dm_rdata;
  } pma_state_t;

  localparam int DM_DEPTH = 1 << PMA_DADDR_W;

  pma_state_t s_q;
  pma_state_t s_d;
  logic [7:0] dmem [DM_DEPTH];
  pma_mem_if fetch_bus ();
  pma_mem_if tbl_bus ();

  // Fold an address into the implemented range.
  function automatic logic [12:0] pma_fold(input logic [12:0] a);
    pma_fold = (WORDS == PMA_WORDS_HALF) ? {1'b0, a[11:0]} : a;
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Program store instance.
  // sized storage
  pma_store #(.DEPTH(WORDS)) u_store (
    .ref_clk(ref_clk),
    .fetch(fetch_bus.store),
    .table_rd(tbl_bus.store),
    .wr_en(pgm_we),
    .wr_addr(pgm_addr),
    .wr_word(pgm_word)
  );

  assign fetch_bus.addr = pma_fold(s_q.pc);
  assign tbl_bus.addr = pma_fold(tbl_addr);

  ////////////////////////////////////////////////////////////////////////
  // Next-state logic; interrupt entry outranks a branch.
  always_comb
  begin
    s_d = s_q;
    s_d.instr = fetch_bus.word;
    if (irq_take)
    begin
      s_d.pc = PMA_IRQ_VEC;
    end
    else if (branch)
    begin
      s_d.pc = branch_addr;
    end
    else
    begin
      s_d.pc = s_q.pc + PMA_PC_STEP;
    end
    s_d.tbl_valid = tbl_req;
    if (tbl_req)
    begin
      s_d.tbl_word = tbl_bus.word;
    end
    s_d.dm_rdata = dmem[dm_addr];
  end

  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      s_q <= '{pc: PMA_RESET_VEC, instr: PMA_WORD_ZERO, tbl_word: PMA_WORD_ZERO,
               tbl_valid: 1'b0, dm_rdata: PMA_DATA_ZERO};
    end
    else
    begin
      s_q <= s_d;
    end
  end

  // Data RAM lives on its own port, so it never stalls a fetch.
  always_ff @(posedge ref_clk)
  begin
    if (dm_we)
    begin
      dmem[dm_addr] <= dm_wdata;
    end
  end

  assign pc = s_q.pc;
  assign instr = s_q.instr;
  assign tbl_word = s_q.tbl_word;
  assign tbl_valid = s_q.tbl_valid;
  assign dm_rdata = s_q.dm_rdata;

  ////////////////////////////////////////////////////////////////////////
  // Checks.
  property p_reset_vec;
    @(posedge ref_clk) $fell(rst) |-> pc == PMA_RESET_VEC;
  endproperty
  a_reset_vec: assert property (p_reset_vec) else $error("pc not at reset vector");

  property p_irq_vec;
    @(posedge ref_clk) disable iff (rst) irq_take |=> pc == PMA_IRQ_VEC;
  endproperty
  a_irq_vec: assert property (p_irq_vec) else $error("interrupt vector missed");

  property p_step;
    @(posedge ref_clk) disable iff (rst)
      !irq_take && !branch |=> pc == $past(pc) + PMA_PC_STEP;
  endproperty
  a_step: assert property (p_step) else $error("pc did not step");

  property p_branch;
    @(posedge ref_clk) disable iff (rst)
      !irq_take && branch |=> pc == $past(branch_addr);
  endproperty
  a_branch: assert property (p_branch) else $error("branch target missed");

  property p_wrap;
    @(posedge ref_clk) disable iff (rst)
      WORDS == PMA_WORDS_HALF |-> fetch_bus.addr[12] == 1'b0;
  endproperty
  a_wrap: assert property (p_wrap) else $error("address not folded");

  property p_fold;
    @(posedge ref_clk) disable iff (rst)
      fetch_bus.addr[11:0] == pc[11:0];
  endproperty
  a_fold: assert property (p_fold) else $error("low address bits changed");

  property p_tbl;
    @(posedge ref_clk) disable iff (rst)
      tbl_req |=> tbl_valid && tbl_word == $past(tbl_bus.word);
  endproperty
  a_tbl: assert property (p_tbl) else $error("table read lost");

  property p_tbl_idle;
    @(posedge ref_clk) disable iff (rst) !tbl_req |=> !tbl_valid;
  endproperty
  a_tbl_idle: assert property (p_tbl_idle) else $error("spurious table valid");

  // Store words are not reset, so an unwritten word must be carried as it stands.
  property p_fetch;
    @(posedge ref_clk) disable iff (rst) 1'b1 |=> instr === $past(fetch_bus.word);
  endproperty
  a_fetch: assert property (p_fetch) else $error("fetch word lost");

  // A data write is read back on its own bus two cycles later.
  property p_dm;
    @(posedge ref_clk) disable iff (rst)
      dm_we ##1 dm_addr == $past(dm_addr) |=> dm_rdata == $past(dm_wdata, 2);
  endproperty
  a_dm: assert property (p_dm) else $error("data word not read back");

  c_irq: cover property (@(posedge ref_clk) disable iff (rst) irq_take);
  c_tbl_irq: cover property (@(posedge ref_clk) disable iff (rst) tbl_req && irq_take);
  c_pc_wrap: cover property (@(posedge ref_clk) disable iff (rst) pc == 13'h1FFF ##1 pc == 13'h0000);
endmodule
`default_nettype wire

/* File: pkg/pma_pkg.sv */
// Package for the program-memory addressing block.
// Assumes a single core clock domain and an active-high asynchronous reset.
package pma_pkg;
  localparam int PMA_PC_W = 13;
  localparam int PMA_WORD_W = 14;
  localparam int PMA_DATA_W = 8;
  localparam int PMA_DADDR_W = 9;
  localparam int PMA_WORDS_FULL = 8192;
  localparam int PMA_WORDS_HALF = 4096;
  localparam logic [12:0] PMA_RESET_VEC = 13'h0000;
  localparam logic [12:0] PMA_IRQ_VEC = 13'h0004;
  localparam logic [12:0] PMA_PC_STEP = 13'h0001;
  localparam logic [13:0] PMA_WORD_ZERO = 14'h0000;
  localparam logic [7:0] PMA_DATA_ZERO = 8'h00;
endpackage

/* File: pkg/pma_mem_if.sv */
// Interface carrying an address to the program store and its word back.
// Assumes the store answers in the same cycle it is addressed.
`timescale 1ns/100ps
`default_nettype none
interface pma_mem_if;
  logic [12:0] addr;
  logic [13:0] word;
  modport core (output addr, input word);
  modport store (input addr, output word);
endinterface
`default_nettype wire

/* File: hw/pma_store.sv */
// Program-word storage array with two asynchronous read ports.
// Assumes contents are loaded through the write port by a programmer.
`timescale 1ns/100ps
`default_nettype none
module pma_store
  import pma_pkg::*;
#(
  parameter int DEPTH = PMA_WORDS_FULL
)
(
  // Clock.
  input wire logic ref_clk,
  // Read port for fetch.
  pma_mem_if.store fetch,
  // Read port for table reads.
  pma_mem_if.store table_rd,
  // Programming write port.
  input wire logic wr_en,
  input wire logic [12:0] wr_addr,
  input wire logic [13:0] wr_word
);
  localparam int AW = $clog2(DEPTH);
  logic [13:0] mem [DEPTH];

  // Unused upper address bits are dropped so accesses wrap into the array.
  always_ff @(posedge ref_clk)
  begin
    if (wr_en)
    begin
      mem[wr_addr[AW-1:0]] <= wr_word;
    end
  end

  // Two independent read ports, so fetch and table read never contend.
  assign fetch.word = mem[fetch.addr[AW-1:0]];
  assign table_rd.word = mem[table_rd.addr[AW-1:0]];
endmodule
`default_nettype wire

/* File: test/pma_loader.sv */
// Programmer model that fills the program store once start is raised, while the core runs.
// Assumes the core takes the programming port at each rising edge.
`timescale 1ns/100ps
`default_nettype none
module pma_loader
(
  // Clock and start.
  input wire logic ref_clk,
  input wire logic start,
  // Programming port.
  output logic pgm_we,
  output logic [12:0] pgm_addr,
  output logic [13:0] pgm_word,
  output logic done
);
  // Writes sixteen words, then one past 4K that must fold onto word 8.
  initial
  begin
    pgm_we = 1'b0;
    pgm_addr = 13'h0000;
    pgm_word = 14'h0000;
    done = 1'b0;
    @(negedge ref_clk iff start);
    for (int i = 0; i < 17; i++)
    begin
      pgm_we = 1'b1;
      pgm_addr = (i == 16) ? 13'h1008 : 13'(i);
      pgm_word = (i == 16) ? 14'h1111 : (14'h03A5 ^ 14'(i));
      @(negedge ref_clk);
    end
    pgm_we = 1'b0;
    // Released lines show no stale value.
    pgm_word = ~pgm_word;
    done = 1'b1;
  end
endmodule
`default_nettype wire

/* File: test/program_memory_addressing_test.sv */
// Self-checking bench for the program-memory addressing core, 4K variant.
// Assumes the loader has filled words 0 to 15 before the scenarios run.
`timescale 1ns/100ps
`default_nettype none
module program_memory_addressing_test;
  logic ref_clk = 1'b0, rst = 1'b1, irq_take = 1'b0, branch = 1'b0, tbl_req = 1'b0;
  logic dm_we = 1'b0, pgm_we, tbl_valid, done;
  logic [12:0] branch_addr = 13'h0000, tbl_addr = 13'h0000, pgm_addr, pc, p0;
  logic [8:0] dm_addr = 9'h000;
  logic [7:0] dm_wdata = 8'h00, dm_rdata;
  logic [13:0] pgm_word, instr, tbl_word;
  int err_total = 0, num_checks = 0;
  always #50 ref_clk = ~ref_clk;
  pma_core #(.WORDS(4096)) i_pma_core (.ref_clk(ref_clk), .rst(rst), .irq_take(irq_take),
    .branch(branch), .branch_addr(branch_addr), .pc(pc), .instr(instr), .tbl_req(tbl_req),
    .tbl_addr(tbl_addr), .tbl_word(tbl_word), .tbl_valid(tbl_valid), .dm_we(dm_we),
    .dm_addr(dm_addr), .dm_wdata(dm_wdata), .dm_rdata(dm_rdata), .pgm_we(pgm_we),
    .pgm_addr(pgm_addr), .pgm_word(pgm_word));
  pma_loader i_pma_loader (.ref_clk(ref_clk), .start(!rst), .pgm_we(pgm_we),
    .pgm_addr(pgm_addr), .pgm_word(pgm_word), .done(done));
  //////////////////////////////////////////////////////////////////////////////
  // Word the loader placed at a folded address.
  function automatic logic [13:0] exp_word(input logic [12:0] a);
    return (a[11:0] == 12'h008) ? 14'h1111 : (14'h03A5 ^ {2'h0, a[11:0]});
  endfunction
  task automatic check(input logic [13:0] seen, input logic [13:0] want);
    num_checks++;
    if (seen !== want)
    begin
      err_total++;
      $display("unexpected at %0t: saw %h, wanted %h", $time, seen, want);
    end
  endtask
  task automatic step();
    @(posedge ref_clk);
    @(negedge ref_clk);
  endtask
  task automatic final_report();
    if (err_total == 0 && num_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  //////////////////////////////////////////////////////////////////////////////
  // Interrupt beats a branch in the same cycle, with a table read beside it.
  task automatic t_irq();
    irq_take = 1'b1;
    branch = 1'b1;
    branch_addr = 13'h000A;
    tbl_req = 1'b1;
    tbl_addr = 13'h0003;
    step();
    irq_take = 1'b0;
    branch = 1'b0;
    tbl_req = 1'b0;
    check(14'(pc), 14'h0004);
    check(14'(tbl_valid), 14'h0001);
    check(tbl_word, exp_word(13'h0003));
    step();
    check(14'(pc), 14'h0005);
    check(instr, exp_word(13'h0004));
    check(14'(tbl_valid), 14'h0000);
  endtask
  // Fetch above 4K folds, and the counter rolls over at the top.
  task automatic t_wrap();
    branch = 1'b1;
    branch_addr = 13'h1002;
    step();
    branch_addr = 13'h1FFF;
    check(14'(pc), 14'h1002);
    step();
    branch = 1'b0;
    check(instr, exp_word(13'h0002));
    step();
    check(14'(pc), 14'h0000);
  endtask
  // Table read above 4K alongside a data write and read.
  task automatic t_table();
    tbl_req = 1'b1;
    tbl_addr = 13'h1008;
    dm_we = 1'b1;
    dm_addr = 9'h1A5;
    dm_wdata = 8'h5C;
    p0 = pc;
    step();
    tbl_req = 1'b0;
    dm_we = 1'b0;
    check(14'(tbl_valid), 14'h0001);
    check(tbl_word, 14'h1111);
    check(14'(pc), 14'(p0 + 13'h0001));
    step();
    check(14'(tbl_valid), 14'h0000);
    check(tbl_word, 14'h1111);
    check(14'(dm_rdata), 14'h005C);
    step();
    check(14'(dm_rdata), 14'h005C);
    check(tbl_word, 14'h1111);
  endtask
  // Reset in mid-run clears the outputs, then fetch restarts at address zero.
  task automatic t_reset();
    rst = 1'b1;
    step();
    check(14'(pc), 14'h0000);
    check(instr, 14'h0000);
    check(tbl_word, 14'h0000);
    check(14'(tbl_valid), 14'h0000);
    check(14'(dm_rdata), 14'h0000);
    rst = 1'b0;
    step();
    check(14'(pc), 14'h0001);
    check(instr, exp_word(13'h0000));
  endtask
  //////////////////////////////////////////////////////////////////////////////
  // Reset, wait for the loader, then run the scenarios.
  initial
  begin
    repeat (20) @(negedge ref_clk);
    check(14'(pc), 14'h0000);
    rst = 1'b0;
    step();
    check(14'(pc), 14'h0001);
    for (int i = 0; i < 100 && !done; i++)
      step();
    // A loader that never finishes counts as a mismatch.
    if (done !== 1'b1)
    begin
      err_total++;
    end
    else
    begin
      t_irq();
      t_wrap();
      t_table();
      t_reset();
    end
    final_report();
  end
endmodule
`default_nettype wire
